//--- pt_defines.svh
// Register map, field positions and constants for the paired timer
`ifndef PT_DEFINES_SVH
`define PT_DEFINES_SVH
`define PT_ADDR_LCON 12'h000
`define PT_ADDR_UCON 12'h004
`define PT_ADDR_LPER 12'h008
`define PT_ADDR_UPER 12'h00c
`define PT_ADDR_LCNT 12'h010
`define PT_ADDR_UCNT 12'h014
`define PT_ADDR_STAT 12'h018
`define PT_CON_MASK 16'ha37a
`define PT_PER_RESET 16'hffff
`define PT_B_RUN 15
`define PT_B_IDLE 13
`define PT_B_ESRC_HI 9
`define PT_B_ESRC_LO 8
`define PT_B_GATE 6
`define PT_B_PS_HI 5
`define PT_B_PS_LO 4
`define PT_B_WIDTH 3
`define PT_B_CSRC 1
`define PT_PS_1 8'h00
`define PT_PS_8 8'h07
`define PT_PS_64 8'h3f
`define PT_PS_256 8'hff
`endif

//--- pt_pkg.sv
// Types shared by the paired timer modules
package pt_pkg;
	typedef enum logic [1:0] {
		PT_SRC_SECONDARY_OSC_CLOCK = 2'b00,
		PT_SRC_PARTNER = 2'b01,
		PT_SRC_LOW_POWER_RC_CLOCK = 2'b10,
		PT_SRC_GENERIC = 2'b11
	} pt_src_e;
	typedef enum logic [1:0] {
		PT_MODE_STOP = 2'b00,
		PT_MODE_COUNT = 2'b01,
		PT_MODE_GATED = 2'b10
	} pt_mode_e;
endpackage : pt_pkg

//--- pt_tick_if.sv
// Tick and control bundle between the top and a prescaler
`timescale 1ns/10ps
interface pt_tick_if;
	logic enable;
	logic restart;
	logic [1:0] ratio;
	logic raw_tick;
	logic tick;
	modport top (output enable, output restart, output ratio, output raw_tick, input tick);
	modport pre (input enable, input restart, input ratio, input raw_tick, output tick);
endinterface : pt_tick_if

//--- pt_prescaler.sv
// Prescaler dividing a raw tick by 1, 8, 64 or 256
`timescale 1ns/10ps
`include "pt_defines.svh"
module pt_prescaler (
	input wire logic clk_sys,
	input wire logic rst,
	pt_tick_if.pre tk
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] limit;
	logic tick_reg;
	assign limit = (tk.ratio == 2'b11) ? `PT_PS_256 : (tk.ratio == 2'b10) ? `PT_PS_64 :
		(tk.ratio == 2'b01) ? `PT_PS_8 : `PT_PS_1;
	assign cnt_next = (cnt_reg >= limit) ? 8'h00 : cnt_reg + 8'h01;
	assign tk.tick = tick_reg;
	always_ff @(posedge clk_sys) begin
		if (rst || tk.restart) begin
			cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= tk.enable && tk.raw_tick && (cnt_reg >= limit);
			if (tk.enable && tk.raw_tick)
				cnt_reg <= cnt_next;
		end
	end
	AST_PS_ONE: assert property (@(posedge clk_sys) disable iff (rst)
		(tk.ratio == 2'b00 && tk.enable && tk.raw_tick && !tk.restart && cnt_reg == 8'h00) |=> tk.tick)
		else $error("Divide by one missed a tick");
	AST_PS_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
		tk.restart |=> (cnt_reg == 8'h00 && !tk.tick))
		else $error("Prescaler not restarted");
endmodule : pt_prescaler

//--- pt_sync.sv
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
module pt_sync (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic meta_reg;
	logic sync_reg;
	assign dout = sync_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end
endmodule : pt_sync

//--- pt_timer.sv
// Paired 16/32-bit timer with APB register access
`timescale 1ns/10ps
`include "pt_defines.svh"
module pt_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic idle_mode,
	input wire logic generic_ext_clock_input,
	input wire logic partner_ext_clock_input,
	input wire logic low_power_rc_clock,
	input wire logic secondary_osc_clock,
	input wire logic lower_gate_input,
	input wire logic upper_gate_input,
	output logic lower_match_flag,
	output logic upper_match_flag,
	output logic converter_trigger
);
	// Clock and gate pins: six inputs synchronised
	logic s_gen, s_par, s_low_power_rc_clock, s_secondary_osc_clock, s_lg, s_ug;
	pt_sync u_s0 (.clk_sys(clk_sys), .rst(rst), .din(generic_ext_clock_input), .dout(s_gen));
	pt_sync u_s1 (.clk_sys(clk_sys), .rst(rst), .din(partner_ext_clock_input), .dout(s_par));
	pt_sync u_s2 (.clk_sys(clk_sys), .rst(rst), .din(low_power_rc_clock), .dout(s_low_power_rc_clock));
	pt_sync u_s3 (.clk_sys(clk_sys), .rst(rst), .din(secondary_osc_clock), .dout(s_secondary_osc_clock));
	pt_sync u_s4 (.clk_sys(clk_sys), .rst(rst), .din(lower_gate_input), .dout(s_lg));
	pt_sync u_s5 (.clk_sys(clk_sys), .rst(rst), .din(upper_gate_input), .dout(s_ug));

	// Registers
	logic [15:0] lower_timer_control_reg, upper_timer_control_reg;
	logic [15:0] lower_period_reg, upper_period_word_reg;
	logic [15:0] lower_count_reg, upper_count_reg;
	logic [15:0] lower_count_next, upper_count_next;
	logic lower_flag_reg, upper_flag_reg, trig_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [3:0] edge_prev_reg;
	logic lg_prev_reg, ug_prev_reg;
	logic pt_tick_half_reg;

	// Bus decode: writes land at the access edge, when pready is sampled high
	wire setup_ph = psel && !penable;
	wire acc_ph = psel && penable && pready_reg;
	wire wr_l = acc_ph && pwrite && paddr == `PT_ADDR_LCON;
	wire wr_u = acc_ph && pwrite && paddr == `PT_ADDR_UCON;
	wire wr_lp = acc_ph && pwrite && paddr == `PT_ADDR_LPER;
	wire wr_up = acc_ph && pwrite && paddr == `PT_ADDR_UPER;
	wire wr_lc = acc_ph && pwrite && paddr == `PT_ADDR_LCNT;
	wire wr_uc = acc_ph && pwrite && paddr == `PT_ADDR_UCNT;
	wire wr_st = acc_ph && pwrite && paddr == `PT_ADDR_STAT;
	wire addr_ok = paddr == `PT_ADDR_LCON || paddr == `PT_ADDR_UCON || paddr == `PT_ADDR_LPER ||
		paddr == `PT_ADDR_UPER || paddr == `PT_ADDR_LCNT || paddr == `PT_ADDR_UCNT || paddr == `PT_ADDR_STAT;
	wire [15:0] wdat = pwdata[15:0] & `PT_CON_MASK;

	// Control fields
	wire pair32 = lower_timer_control_reg[`PT_B_WIDTH];
	// upper fields replaced by lower ones in 32-bit mode
	wire [15:0] ucon = pair32 ? lower_timer_control_reg : upper_timer_control_reg;
	wire l_run = lower_timer_control_reg[`PT_B_RUN] && !(idle_mode && lower_timer_control_reg[`PT_B_IDLE]);
	wire u_run = ucon[`PT_B_RUN] && !(idle_mode && ucon[`PT_B_IDLE]);
	wire l_ext = lower_timer_control_reg[`PT_B_CSRC];
	wire u_ext = ucon[`PT_B_CSRC];
	wire l_gated = !l_ext && lower_timer_control_reg[`PT_B_GATE];
	wire u_gated = !u_ext && ucon[`PT_B_GATE];

	// Source select and rising-edge detect on synchronised clocks
	wire [3:0] src_now = {s_gen, s_low_power_rc_clock, s_par, s_secondary_osc_clock};
	wire [3:0] src_rise = src_now & ~edge_prev_reg;
	function automatic logic pick(input logic [1:0] sel, input logic [3:0] r);
		case (pt_pkg::pt_src_e'(sel))
			pt_pkg::PT_SRC_GENERIC: pick = r[3];
			pt_pkg::PT_SRC_LOW_POWER_RC_CLOCK: pick = r[2];
			pt_pkg::PT_SRC_PARTNER: pick = r[1];
			pt_pkg::PT_SRC_SECONDARY_OSC_CLOCK: pick = r[0];
			default: pick = 1'b0;
		endcase
	endfunction : pick
	wire l_ext_tick = pick(lower_timer_control_reg[`PT_B_ESRC_HI:`PT_B_ESRC_LO], src_rise);
	wire u_ext_tick = pick(ucon[`PT_B_ESRC_HI:`PT_B_ESRC_LO], src_rise);
	// Internal rate is system oscillator/2: one pulse every other cycle
	wire l_gate_ok = !l_gated || s_lg;
	wire u_gate_ok = !u_gated || (pair32 ? s_lg : s_ug);
	wire l_raw = (l_ext ? l_ext_tick : pt_tick_half_reg) && l_gate_ok;
	wire u_raw = (u_ext ? u_ext_tick : pt_tick_half_reg) && u_gate_ok;

	pt_tick_if l_tk ();
	pt_tick_if u_tk ();
	assign l_tk.enable = l_run;
	assign l_tk.restart = wr_l && lower_timer_control_reg[`PT_B_RUN];
	assign l_tk.ratio = lower_timer_control_reg[`PT_B_PS_HI:`PT_B_PS_LO];
	assign l_tk.raw_tick = l_raw;
	assign u_tk.enable = u_run && !pair32;
	assign u_tk.restart = wr_u && upper_timer_control_reg[`PT_B_RUN] && !pair32;
	assign u_tk.ratio = ucon[`PT_B_PS_HI:`PT_B_PS_LO];
	assign u_tk.raw_tick = u_raw;
	pt_prescaler u_pl (.clk_sys(clk_sys), .rst(rst), .tk(l_tk.pre));
	pt_prescaler u_pu (.clk_sys(clk_sys), .rst(rst), .tk(u_tk.pre));

	// Counting and period match
	wire l_tick = l_tk.tick;
	wire u_tick = u_tk.tick;
	wire [31:0] cnt32 = {upper_count_reg, lower_count_reg};
	wire [31:0] per32 = {upper_period_word_reg, lower_period_reg};
	wire match32 = pair32 && l_tick && cnt32 == per32;
	wire match_l = !pair32 && l_tick && lower_count_reg == lower_period_reg;
	wire match_u = !pair32 && u_tick && upper_count_reg == upper_period_word_reg;
	wire [31:0] cnt32_inc = cnt32 + 32'h0000_0001;
	wire lg_fall = l_gated && lg_prev_reg && !s_lg;
	wire ug_fall = !pair32 && u_gated && ug_prev_reg && !s_ug;

	always_comb begin
		lower_count_next = lower_count_reg;
		upper_count_next = upper_count_reg;
		if (pair32) begin
			if (match32) begin
				lower_count_next = 16'h0000;
				upper_count_next = 16'h0000;
			end else if (l_tick) begin
				lower_count_next = cnt32_inc[15:0];
				upper_count_next = cnt32_inc[31:16];
			end
		end else begin
			if (match_l)
				lower_count_next = 16'h0000;
			else if (l_tick)
				lower_count_next = lower_count_reg + 16'h0001;
			if (match_u)
				upper_count_next = 16'h0000;
			else if (u_tick)
				upper_count_next = upper_count_reg + 16'h0001;
		end
		if (wr_lc)
			lower_count_next = pwdata[15:0];
		if (wr_uc)
			upper_count_next = pwdata[15:0];
	end

	// Flags: status write of one clears, a new event wins
	wire l_evt = match_l || (lg_fall && !pair32);
	wire u_evt = match_u || match32 || ug_fall || (lg_fall && pair32);
	wire [31:0] rd_mux = (paddr == `PT_ADDR_LCON) ? {16'h0000, lower_timer_control_reg} :
		(paddr == `PT_ADDR_UCON) ? {16'h0000, upper_timer_control_reg} :
		(paddr == `PT_ADDR_LPER) ? {16'h0000, lower_period_reg} :
		(paddr == `PT_ADDR_UPER) ? {16'h0000, upper_period_word_reg} :
		(paddr == `PT_ADDR_LCNT) ? {16'h0000, lower_count_reg} :
		(paddr == `PT_ADDR_UCNT) ? {16'h0000, upper_count_reg} :
		(paddr == `PT_ADDR_STAT) ? {30'h0000_0000, upper_flag_reg, lower_flag_reg} : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lower_timer_control_reg <= 16'h0000;
			upper_timer_control_reg <= 16'h0000;
			lower_period_reg <= `PT_PER_RESET;
			upper_period_word_reg <= `PT_PER_RESET;
			lower_count_reg <= 16'h0000;
			upper_count_reg <= 16'h0000;
			edge_prev_reg <= 4'h0;
			lg_prev_reg <= 1'b0;
			ug_prev_reg <= 1'b0;
			pt_tick_half_reg <= 1'b0;
		end else begin
			if (wr_l)
				lower_timer_control_reg <= wdat;
			if (wr_u)
				upper_timer_control_reg <= wdat & ~(16'h0001 << `PT_B_WIDTH);
			if (wr_lp)
				lower_period_reg <= pwdata[15:0];
			if (wr_up)
				upper_period_word_reg <= pwdata[15:0];
			lower_count_reg <= lower_count_next;
			upper_count_reg <= upper_count_next;
			edge_prev_reg <= src_now;
			lg_prev_reg <= s_lg;
			ug_prev_reg <= s_ug;
			pt_tick_half_reg <= !pt_tick_half_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lower_flag_reg <= 1'b0;
			upper_flag_reg <= 1'b0;
			trig_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			lower_flag_reg <= l_evt || (lower_flag_reg && !(wr_st && pwdata[0]));
			upper_flag_reg <= u_evt || (upper_flag_reg && !(wr_st && pwdata[1]));
			trig_reg <= match32 || match_u;
			pready_reg <= setup_ph;
			pslverr_reg <= setup_ph && !addr_ok;
			if (setup_ph && !pwrite)
				prdata_reg <= rd_mux;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign lower_match_flag = lower_flag_reg;
	assign upper_match_flag = upper_flag_reg;
	assign converter_trigger = trig_reg;

	AST_MATCH_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
		(match_l && !wr_lc) |=> (lower_count_reg == 16'h0000 && lower_match_flag))
		else $error("Lower match did not clear count");
	AST_PAIR_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
		match32 |=> (upper_match_flag && converter_trigger && !$rose(lower_match_flag)))
		else $error("Pair match not on upper flag");
	AST_CARRY: assert property (@(posedge clk_sys) disable iff (rst)
		(pair32 && l_tick && !match32 && lower_count_reg == 16'hffff && !wr_lc && !wr_uc)
		|=> upper_count_reg == $past(upper_count_reg) + 16'h0001)
		else $error("Low word wrap did not carry");
	AST_STOPPED: assert property (@(posedge clk_sys) disable iff (rst)
		(!lower_timer_control_reg[`PT_B_RUN] && !wr_lc) |=> $stable(lower_count_reg))
		else $error("Stopped lower timer counted");
	AST_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
		(idle_mode && lower_timer_control_reg[`PT_B_IDLE]) |-> !l_tk.enable ##1 !l_tk.tick)
		else $error("Timer ran in idle");
	AST_UPPER_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
		pair32 |-> !u_tk.enable)
		else $error("Upper control acted in pair mode");
	AST_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
		((lower_timer_control_reg | upper_timer_control_reg) & ~`PT_CON_MASK) == 16'h0000)
		else $error("Unimplemented bit set");
	AST_GATE_FALL: assert property (@(posedge clk_sys) disable iff (rst)
		(lg_fall && !pair32) |=> lower_match_flag)
		else $error("Gate fall missed flag");
	AST_INT_HALF: assert property (@(posedge clk_sys) disable iff (rst)
		(!l_ext && !l_gated && $past(!l_ext && !l_gated) && !$past(rst)) |-> (l_raw != $past(l_raw)))
		else $error("Internal clock not half rate");
	AST_TRIG_SRC: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(converter_trigger) |-> $past(match32 || match_u))
		else $error("Trigger from wrong timer");
endmodule : pt_timer

//--- pt_ext_model.sv
// Partner model: external timer clocks and gate levels
`timescale 1ns/10ps
module pt_ext_model (
	input wire logic [3:0] en,
	input wire logic [1:0] gate_cmd,
	output logic [3:0] clk_ext,
	output logic [1:0] gate
);
	initial clk_ext = 4'h0;
	// Half period off the 40 ns grid, so edges drift against the system clock
	always begin
		#117;
		clk_ext <= ~clk_ext & en;
	end
	assign gate = gate_cmd;
endmodule : pt_ext_model

//--- pt_timer_tb_top.sv
// Self-checking testbench for the paired timer
`timescale 1ns/10ps
`include "pt_defines.svh"
module pt_timer_tb_top;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} pt_note_s;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic idle_mode = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] seed = 32'he0fe7d43;
	logic [31:0] prdata;
	logic pready, pslverr, lflag, uflag, trig;
	logic [3:0] en = 4'h0;
	logic [3:0] clk_ext;
	logic [1:0] gate_cmd = 2'h0;
	logic [1:0] gate;
	int err_total = 0;
	int n_checks = 0;
	pt_note_s q[$];
	always #20 clk_sys = ~clk_sys;
	pt_timer i_pt_timer (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.idle_mode(idle_mode), .generic_ext_clock_input(clk_ext[3]), .partner_ext_clock_input(clk_ext[1]),
		.low_power_rc_clock(clk_ext[2]), .secondary_osc_clock(clk_ext[0]), .lower_gate_input(gate[0]),
		.upper_gate_input(gate[1]), .lower_match_flag(lflag), .upper_match_flag(uflag), .converter_trigger(trig));
	pt_ext_model i_pt_ext_model (.en(en), .gate_cmd(gate_cmd), .clk_ext(clk_ext), .gate(gate));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chk_near(input string nm, input int exp, input int tol, input int got);
		n_checks++;
		if (got < exp - tol || got > exp + tol) begin
			err_total++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : chk_near
	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	// For reads d is the expected data; the monitor compares under mask m
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e, output logic [31:0] rd);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back('{w ? 32'h0 : d, m, e});
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) chk("pready", 32'h1, 32'h0);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		apb(1'b1, a, d, 32'h0, 1'b0, v);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] v;
		apb(1'b0, a, e, m, 1'b0, v);
	endtask : rdc
	always @(posedge clk_sys) begin
		pt_note_s nt;
		if (psel && penable && pready === 1'b1) begin
			nt = q.pop_front();
			chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
			chk("prdata", nt.d & nt.m, prdata & nt.m);
		end
	end
	task automatic prep(input logic [15:0] lc, input logic [15:0] lp, input logic [15:0] up);
		wr(`PT_ADDR_LCON, 32'h0);
		wr(`PT_ADDR_UCON, 32'h0);
		wr(`PT_ADDR_STAT, 32'h3);
		wr(`PT_ADDR_LCNT, {16'h0, lc});
		wr(`PT_ADDR_UCNT, 32'h0);
		wr(`PT_ADDR_LPER, {16'h0, lp});
		wr(`PT_ADDR_UPER, {16'h0, up});
	endtask : prep
	task automatic wflag(input logic f, output int n, output logic tr);
		n = 0;
		tr = 1'b0;
		while ((f ? uflag : lflag) !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
			tr |= trig;
		end
		repeat (3) begin
			@(posedge clk_sys);
			tr |= trig;
		end
	endtask : wflag
	task automatic meas(input logic [11:0] a, input logic [15:0] con, input logic f, input int exp, input logic te);
		int n;
		logic tr;
		wr(a, {16'h0, con});
		wflag(f, n, tr);
		chk_near("cycles to match", exp, 10, n);
		chk("converter trigger", {31'h0, te}, {31'h0, tr});
	endtask : meas
	initial begin
		#800000;
		err_total++;
		final_report;
	end
	initial begin
		int n;
		logic tr;
		logic [31:0] x;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a <= 24; a += 4) rdc(a[11:0], (a == 8 || a == 12) ? 32'hffff : 32'h0, 32'hffffffff);
		apb(1'b1, 12'h01c, xs(), 32'h0, 1'b1, x);
		apb(1'b0, 12'h01c, 32'h0, 32'hffffffff, 1'b1, x);
		// Run bit masked off so random patterns never start a timer
		repeat (4) begin
			x = xs() & 32'h00007fff;
			wr(`PT_ADDR_LCON, x);
			rdc(`PT_ADDR_LCON, x & 32'h237a, 32'hffffffff);
			wr(`PT_ADDR_UCON, x);
			rdc(`PT_ADDR_UCON, x & 32'h2372, 32'hffffffff);
			wr(`PT_ADDR_LCNT, x);
			rdc(`PT_ADDR_LCNT, x & 32'hffff, 32'hffffffff);
		end
		for (int p = 0; p < 4; p++) begin
			n = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
			prep(16'h0, 16'h2, 16'hffff);
			meas(`PT_ADDR_LCON, {8'h80, 2'b00, p[1:0], 4'h0}, 1'b0, 6 * n, 1'b0);
			prep(16'h0, 16'hffff, 16'h2);
			meas(`PT_ADDR_UCON, {8'h80, 2'b00, p[1:0], 4'h0}, 1'b1, 6 * n, 1'b1);
		end
		for (int s = 0; s < 4; s++) begin
			en <= 4'h1 << s;
			prep(16'h0, 16'h3, 16'h3);
			meas(`PT_ADDR_LCON, {6'h20, s[1:0], 8'h42}, 1'b0, 28, 1'b0);
			prep(16'h0, 16'h3, 16'h3);
			meas(`PT_ADDR_UCON, {6'h20, s[1:0], 8'h42}, 1'b1, 28, 1'b1);
		end
		en <= 4'h0;
		// Upper control set to run on a dead clock: pair must ignore it
		prep(16'hfff0, 16'h2, 16'h1);
		wr(`PT_ADDR_UCON, 32'h8032);
		meas(`PT_ADDR_LCON, 16'h8008, 1'b1, 40, 1'b1);
		chk("lower flag in pair mode", 32'h0, {31'h0, lflag});
		prep(16'h0, 16'hffff, 16'hffff);
		idle_mode <= 1'b1;
		wr(`PT_ADDR_LCON, 32'ha000);
		repeat (40) @(posedge clk_sys);
		rdc(`PT_ADDR_LCNT, 32'h0, 32'hffff);
		wr(`PT_ADDR_LCON, 32'h8000);
		repeat (40) @(posedge clk_sys);
		apb(1'b0, `PT_ADDR_LCNT, 32'h0, 32'h0, 1'b0, x);
		chk_near("count in idle", 20, 4, int'(x[15:0]));
		idle_mode <= 1'b0;
		prep(16'h0, 16'hffff, 16'hffff);
		wr(`PT_ADDR_LCON, 32'h8040);
		repeat (30) @(posedge clk_sys);
		rdc(`PT_ADDR_LCNT, 32'h0, 32'hffff);
		gate_cmd <= 2'b01;
		repeat (30) @(posedge clk_sys);
		gate_cmd <= 2'b00;
		wflag(1'b0, n, tr);
		chk_near("gate fall to flag", 4, 4, n);
		// Without a prescaler restart the match would land about 300 cycles early
		prep(16'h0, 16'h0, 16'hffff);
		wr(`PT_ADDR_LCON, 32'h8030);
		repeat (300) @(posedge clk_sys);
		wr(`PT_ADDR_LCON, 32'h8030);
		wflag(1'b0, n, tr);
		chk_near("match after rewrite", 512, 12, n);
		final_report;
	end
endmodule : pt_timer_tb_top
